//--- hw/tbsync_regs.svh
`ifndef TBSYNC_REGS_SVH
`define TBSYNC_REGS_SVH

// ----------------------------------------
// Selector encodings (ten-bit field value)
// ----------------------------------------
`define TBS_SEL_TB_LOW_READ   10'h10c
`define TBS_SEL_TB_HIGH_READ  10'h10d
`define TBS_SEL_TB_LOW_WRITE  10'h11c
`define TBS_SEL_TB_HIGH_WRITE 10'h11d

// ----------------------------------------
// Instruction field positions
// ----------------------------------------
`define TBS_OPCD_HI    31
`define TBS_OPCD_LO    26
`define TBS_RD_HI      25
`define TBS_RD_LO      21
`define TBS_SELA_HI    20
`define TBS_SELA_LO    16
`define TBS_SELB_HI    15
`define TBS_SELB_LO    11
`define TBS_XO_HI      10
`define TBS_XO_LO      1

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define TBS_OPCD_X     6'h1f
`define TBS_XO_RDTB    10'h173
`define TBS_XO_WRSPR   10'h1d3
`define TBS_XO_IOBAR   10'h356
`define TBS_XO_FULLBAR 10'h256
`define TBS_OPCD_ISB   6'h13
`define TBS_XO_ISB     10'h096

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TBS_TB_RESET   64'h0

`endif

//--- hw/tbs_pkg.sv
package tbs_pkg;

    typedef enum logic [2:0] {
        TBS_OP_NONE,
        TBS_OP_RD_LOW,
        TBS_OP_RD_HIGH,
        TBS_OP_WR_LOW,
        TBS_OP_WR_HIGH,
        TBS_OP_IOBAR,
        TBS_OP_FULLBAR,
        TBS_OP_ISB
    } tbs_op_e;

    typedef struct packed {
        tbs_op_e    op;
        logic [4:0] rd;
        logic       illegal;
        logic       privileged;
    } tbs_dec_s;

    typedef struct packed {
        logic        valid;
        logic [4:0]  rd;
        logic [31:0] data;
    } tbs_wb_s;

endpackage : tbs_pkg

//--- hw/tbs_decode.sv
`include "tbsync_regs.svh"

module tbs_decode
    import tbs_pkg::*;
(
    input  wire logic [31:0] insn,
    output tbs_dec_s         dec
);

    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // Field extraction
    // ----------------------------------------
    wire logic [5:0] opcd = insn[`TBS_OPCD_HI:`TBS_OPCD_LO];
    wire logic [9:0] xo   = insn[`TBS_XO_HI:`TBS_XO_LO];
    // Halves are swapped in the encoding
    wire logic [9:0] sel  = {insn[`TBS_SELB_HI:`TBS_SELB_LO],
                             insn[`TBS_SELA_HI:`TBS_SELA_LO]};
    wire logic       is_x = (opcd == `TBS_OPCD_X);
    wire logic       rdtb = is_x && (xo == `TBS_XO_RDTB);
    wire logic       wrsp = is_x && (xo == `TBS_XO_WRSPR);

    always_comb begin
        dec.op         = TBS_OP_NONE;
        dec.rd         = insn[`TBS_RD_HI:`TBS_RD_LO];
        dec.illegal    = 1'b0;
        dec.privileged = 1'b0;
        if (rdtb) begin
            case (sel)
                `TBS_SEL_TB_LOW_READ:  dec.op = TBS_OP_RD_LOW;
                `TBS_SEL_TB_HIGH_READ: dec.op = TBS_OP_RD_HIGH;
                default:               dec.illegal = 1'b1;
            endcase
        end else if (wrsp) begin
            dec.privileged = 1'b1;
            case (sel)
                `TBS_SEL_TB_LOW_WRITE:  dec.op = TBS_OP_WR_LOW;
                `TBS_SEL_TB_HIGH_WRITE: dec.op = TBS_OP_WR_HIGH;
                default:                dec.illegal = 1'b1;
            endcase
        end else if (is_x && xo == `TBS_XO_IOBAR) begin
            dec.op = TBS_OP_IOBAR;
        end else if (is_x && xo == `TBS_XO_FULLBAR) begin
            dec.op = TBS_OP_FULLBAR;
        end else if (opcd == `TBS_OPCD_ISB && xo == `TBS_XO_ISB) begin
            dec.op = TBS_OP_ISB;
        end
    end

endmodule : tbs_decode

//--- hw/tbs_unit.sv
`include "tbsync_regs.svh"

module tbs_unit
    import tbs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        insn_valid,
    input  wire logic [31:0] insn,
    input  wire logic [31:0] insn_pc,
    input  wire logic        supervisor,
    input  wire logic [31:0] src_data,
    input  wire logic        tb_tick,
    input  wire logic        pipe_empty,
    input  wire logic        mem_ops_done,
    input  wire logic        mem_global_done,
    output logic             insn_ready,
    output tbs_wb_s          wb,
    output logic             illegal_insn,
    output logic             priv_fault,
    output logic             fetch_flush,
    output logic [31:0]      fetch_pc,
    output logic             order_req,
    output logic             full_bar_req,
    output logic [63:0]      time_base
);

    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    tbs_dec_s dec;

    tbs_decode u_dec (
        .insn (insn),
        .dec  (dec)
    );

    typedef enum logic [1:0] {
        TBS_ST_IDLE,
        TBS_ST_IOBAR,
        TBS_ST_ISB,
        TBS_ST_FULLBAR
    } tbs_state_e;

    tbs_state_e  state_q,   state_d;
    logic [63:0] tb_q,      tb_d;
    logic [31:0] pc_q,      pc_d;
    tbs_wb_s     wb_q,      wb_d;
    logic        ill_q,     ill_d;
    logic        pf_q,      pf_d;
    logic        flush_q,   flush_d;
    logic [31:0] fpc_q,     fpc_d;
    logic        ord_q,     ord_d;
    logic        fbar_q,    fbar_d;
    logic        rdy_q,     rdy_d;

    wire logic take     = insn_valid && rdy_q && (state_q == TBS_ST_IDLE);
    wire logic priv_bad = dec.privileged && !supervisor;
    wire logic do_op    = take && !dec.illegal && !priv_bad;
    wire logic [31:0] next_pc = insn_pc + 32'h4;

    // ----------------------------------------
    // Time base update
    // ----------------------------------------
    always_comb begin
        tb_d = tb_q + {63'h0, tb_tick};
        if (do_op && dec.op == TBS_OP_WR_LOW) begin
            tb_d = {tb_q[63:32], src_data};
        end else if (do_op && dec.op == TBS_OP_WR_HIGH) begin
            tb_d = {src_data, tb_q[31:0]};
        end
    end

    // ----------------------------------------
    // Read-back and faults
    // ----------------------------------------
    always_comb begin
        wb_d       = '0;
        wb_d.rd    = dec.rd;
        ill_d      = take && dec.illegal;
        pf_d       = take && !dec.illegal && priv_bad;
        if (do_op && dec.op == TBS_OP_RD_LOW) begin
            wb_d.valid = 1'b1;
            wb_d.data  = tb_q[31:0];
        end else if (do_op && dec.op == TBS_OP_RD_HIGH) begin
            wb_d.valid = 1'b1;
            wb_d.data  = tb_q[63:32];
        end
    end

    // ----------------------------------------
    // Barrier sequencing
    // ----------------------------------------
    always_comb begin
        state_d = state_q;
        pc_d    = pc_q;
        flush_d = 1'b0;
        fpc_d   = fpc_q;
        ord_d   = 1'b0;
        fbar_d  = 1'b0;
        rdy_d   = 1'b1;
        case (state_q)
            TBS_ST_IDLE: begin
                if (do_op && dec.op == TBS_OP_IOBAR) begin
                    state_d = TBS_ST_IOBAR;
                    ord_d   = 1'b1;
                    rdy_d   = 1'b0;
                end else if (do_op && dec.op == TBS_OP_ISB) begin
                    state_d = TBS_ST_ISB;
                    pc_d    = next_pc;
                    rdy_d   = 1'b0;
                end else if (do_op && dec.op == TBS_OP_FULLBAR) begin
                    state_d = TBS_ST_FULLBAR;
                    fbar_d  = 1'b1;
                    rdy_d   = 1'b0;
                end
            end
            TBS_ST_IOBAR: begin
                // Wait is open-ended on the memory side
                ord_d = 1'b1;
                rdy_d = 1'b0;
                if (mem_ops_done) begin
                    state_d = TBS_ST_IDLE;
                    ord_d   = 1'b0;
                    rdy_d   = 1'b1;
                end
            end
            TBS_ST_ISB: begin
                rdy_d = 1'b0;
                // Only completion, no global perform; no cache action
                if (pipe_empty) begin
                    state_d = TBS_ST_IDLE;
                    flush_d = 1'b1;
                    fpc_d   = pc_q;
                    rdy_d   = 1'b1;
                end
            end
            TBS_ST_FULLBAR: begin
                fbar_d = 1'b1;
                rdy_d  = 1'b0;
                if (pipe_empty && mem_global_done) begin
                    state_d = TBS_ST_IDLE;
                    fbar_d  = 1'b0;
                    rdy_d   = 1'b1;
                end
            end
            default: begin
                state_d = TBS_ST_IDLE;
            end
        endcase
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= TBS_ST_IDLE;
            tb_q    <= `TBS_TB_RESET;
            pc_q    <= '0;
            wb_q    <= '0;
            ill_q   <= 1'b0;
            pf_q    <= 1'b0;
            flush_q <= 1'b0;
            fpc_q   <= '0;
            ord_q   <= 1'b0;
            fbar_q  <= 1'b0;
            rdy_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            tb_q    <= tb_d;
            pc_q    <= pc_d;
            wb_q    <= wb_d;
            ill_q   <= ill_d;
            pf_q    <= pf_d;
            flush_q <= flush_d;
            fpc_q   <= fpc_d;
            ord_q   <= ord_d;
            fbar_q  <= fbar_d;
            rdy_q   <= rdy_d;
        end
    end

    assign insn_ready   = rdy_q;
    assign wb           = wb_q;
    assign illegal_insn = ill_q;
    assign priv_fault   = pf_q;
    assign fetch_flush  = flush_q;
    assign fetch_pc     = fpc_q;
    assign order_req    = ord_q;
    assign full_bar_req = fbar_q;
    assign time_base    = tb_q;

endmodule : tbs_unit

//--- test/tbs_unit_assertions.sv
module tbs_unit_assertions
    import tbs_pkg::*;
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        insn_valid,
    input wire logic [31:0] insn,
    input wire logic [31:0] insn_pc,
    input wire logic        supervisor,
    input wire logic [31:0] src_data,
    input wire logic        tb_tick,
    input wire logic        pipe_empty,
    input wire logic        mem_ops_done,
    input wire logic        mem_global_done,
    input wire logic        insn_ready,
    input wire tbs_wb_s     wb,
    input wire logic        illegal_insn,
    input wire logic        priv_fault,
    input wire logic        fetch_flush,
    input wire logic [31:0] fetch_pc,
    input wire logic        order_req,
    input wire logic        full_bar_req,
    input wire logic [63:0] time_base
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ----
    // Decode of the instruction taken
    // ----
    wire [9:0] sl   = {insn[15:11], insn[20:16]};
    wire [9:0] xo   = insn[10:1];
    wire       tk   = insn_valid && insn_ready;
    wire       x    = tk && insn[31:26] == 6'h1f;
    wire       rdt  = x && xo == 10'h173;
    wire       wrt  = x && xo == 10'h1d3;
    wire       ist  = tk && insn[31:26] == 6'h13 && xo == 10'h096;
    wire       rdok = sl == 10'h10c || sl == 10'h10d;
    wire       wrok = sl == 10'h11c || sl == 10'h11d;
    logic        isb_q;
    logic [31:0] pc_q;
    always_ff @(posedge clk) begin
        if (sys_rst) isb_q <= 1'b0;
        else if (ist) isb_q <= 1'b1;
        else if (pipe_empty) isb_q <= 1'b0;
    end
    always_ff @(posedge clk) begin
        if (ist) pc_q <= insn_pc;
    end
    sequence s_iob; x && xo == 10'h356; endsequence
    sequence s_fb; x && xo == 10'h256; endsequence
    sequence s_isb_end; isb_q && pipe_empty; endsequence
    AST_RD: assert property (
        rdt && rdok |=> wb.valid && wb.rd == $past(insn[25:21]) &&
        wb.data == ($past(sl[0]) ? $past(time_base[63:32])
                                 : $past(time_base[31:0])))
        else $error("read returned wrong half");
    AST_RD_KEEP: assert property (
        rdt && !tb_tick |=> $stable(time_base))
        else $error("read changed the counter");
    AST_WR_LOW: assert property (
        wrt && supervisor && sl == 10'h11c |=>
        time_base == {$past(time_base[63:32]), $past(src_data)})
        else $error("low half write wrong");
    AST_WR_HIGH: assert property (
        wrt && supervisor && sl == 10'h11d |=>
        time_base == {$past(src_data), $past(time_base[31:0])})
        else $error("high half write wrong");
    AST_PRIV: assert property (
        wrt && !supervisor && wrok |=> priv_fault && !wb.valid)
        else $error("user write not refused");
    AST_ILLEGAL: assert property (
        rdt && !rdok || wrt && supervisor && !wrok |=> illegal_insn)
        else $error("bad selector not flagged");
    AST_IOB: assert property (
        s_iob |=> order_req && !insn_ready)
        else $error("ordering barrier did not start");
    AST_FB: assert property (
        s_fb |=> full_bar_req && !insn_ready)
        else $error("full barrier did not start");
    AST_BAR_HOLD: assert property (
        order_req && !mem_ops_done || full_bar_req && !mem_global_done
        |=> !insn_ready && (order_req || full_bar_req))
        else $error("barrier released early");
    AST_ISB_WAIT: assert property (
        isb_q && !pipe_empty |=> !insn_ready && !fetch_flush)
        else $error("sync barrier let work through");
    AST_ISB_FLUSH: assert property (
        s_isb_end |=> fetch_flush && insn_ready &&
        fetch_pc == $past(pc_q) + 32'h4)
        else $error("sync barrier refetch wrong");
    AST_ISB_QUIET: assert property (
        isb_q |-> !order_req && !full_bar_req)
        else $error("sync barrier touched memory side");
endmodule : tbs_unit_assertions
bind tbs_unit tbs_unit_assertions u_tbs_unit_assertions (.*);

//--- test/tbs_mem_model.sv
module tbs_mem_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic insn_ready,
    input wire logic order_req,
    input wire logic full_bar_req,
    output logic     pipe_empty,
    output logic     mem_ops_done,
    output logic     mem_global_done
);
    timeunit 1ns;
    timeprecision 100ps;
    int         seed = 77373;
    logic [3:0] cnt_q, lim_q;
    // ----
    // Random drain time of 0 to 15 cycles per stall
    // ----
    always @(posedge clk) begin
        if (sys_rst || insn_ready) begin
            cnt_q <= 4'h0;
            lim_q <= 4'($random(seed));
        end else if (cnt_q != lim_q) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    wire hit = !sys_rst && !insn_ready && cnt_q == lim_q;
    assign pipe_empty      = hit;
    assign mem_ops_done    = hit && order_req;
    assign mem_global_done = hit && full_bar_req;
endmodule : tbs_mem_model

//--- test/tbs_tb_top.sv
module time_base_access_and_sync_barriers_tb_top
    import tbs_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 0, sys_rst = 1, insn_valid = 0, supervisor = 1;
    logic [31:0] insn = 0, insn_pc = 0, src_data = 0, fetch_pc, lo, hi;
    logic        tb_tick = 0, insn_ready, illegal_insn, priv_fault;
    logic        fetch_flush, order_req, full_bar_req;
    logic        pipe_empty, mem_ops_done, mem_global_done;
    logic [63:0] time_base;
    tbs_wb_s     wb;
    logic [33:0] q[$];
    int          seed = 77373, err_total = 0, comparisons = 0;
    always #5 clk = ~clk;
    tbs_unit u_tbs_unit (.*);
    tbs_mem_model u_tbs_mem_model (.*);
    task automatic summarize();
        $display("comparisons %0d errors %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : summarize
    task automatic check(logic [33:0] got, logic [33:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // ----
    // Offer one instruction, hold it until taken
    // ----
    task automatic op(logic [5:0] oc, logic [9:0] sl, logic [9:0] xo,
                      logic sup, logic [31:0] d);
        int n;
        n = 0;
        insn_valid = 1;
        insn = {oc, 5'($random(seed)), sl[4:0], sl[9:5], xo, 1'b0};
        insn_pc = $random(seed);
        supervisor = sup;
        src_data = d;
        // Ready read mid-cycle, where it stands until the take edge
        @(negedge clk);
        while (!insn_ready && n < 100) begin
            @(negedge clk);
            n++;
        end
        @(posedge clk);
        #1;
        if (n >= 100) begin
            err_total++;
            summarize();
        end
    endtask : op
    task automatic rd(logic h);
        q.push_back({2'd0, h ? hi : lo});
        op(6'h1f, h ? 10'h10d : 10'h10c, 10'h173, 1'b1, 32'h0);
    endtask : rd
    task automatic wr(logic h, logic sup, logic [31:0] d);
        if (!sup) q.push_back({2'd2, 32'h0});
        else if (h) hi = d;
        else lo = d;
        op(6'h1f, h ? 10'h11d : 10'h11c, 10'h1d3, sup, d);
    endtask : wr
    // ----
    // Result watcher
    // ----
    // Results sampled mid-cycle, away from the edge that launches them
    always @(negedge clk) begin
        if (!sys_rst && (wb.valid || illegal_insn || priv_fault ||
                         fetch_flush))
            check({wb.valid ? 2'd0 : illegal_insn ? 2'd1 :
                   priv_fault ? 2'd2 : 2'd3,
                   wb.valid ? wb.data : fetch_flush ? fetch_pc : 32'h0},
                  q.size() ? q.pop_front() : '1);
    end
    initial begin
        repeat (8) @(posedge clk);
        #1 sys_rst = 0;
        repeat (2) @(posedge clk);
        #1;
        lo = 0;
        hi = 0;
        rd(0);
        wr(0, 1, $random(seed));
        wr(1, 1, $random(seed));
        rd(0);
        rd(1);
        wr(1, 0, $random(seed));
        rd(1);
        q.push_back({2'd1, 32'h0});
        op(6'h1f, 10'h10e, 10'h173, 1'b1, 32'h0);
        q.push_back({2'd1, 32'h0});
        op(6'h1f, 10'h11e, 10'h1d3, 1'b1, 32'h5);
        wr(0, 1, 32'hffff_fffe);
        wr(1, 1, 32'h1);
        insn_valid = 0;
        tb_tick = 1;
        repeat (5) @(posedge clk);
        #1 tb_tick = 0;
        lo = 32'h3;
        hi = 32'h2;
        rd(0);
        rd(1);
        op(6'h1f, 10'h0, 10'h356, 1'b1, 32'h0);
        rd(0);
        op(6'h1f, 10'h0, 10'h256, 1'b1, 32'h0);
        op(6'h13, 10'h0, 10'h096, 1'b1, 32'h0);
        q.push_back({2'd3, insn_pc + 32'h4});
        rd(1);
        insn_valid = 0;
        repeat (20) @(posedge clk);
        check(34'(q.size()), 34'h0);
        summarize();
    end
endmodule : time_base_access_and_sync_barriers_tb_top
